// ==== hdl/wl_level.sv ====
// write-leveling logic of the memory device with its register slave
`timescale 1ns/100ps
`include "wl_regs.svh"
//
// Contract
// - mode register one bit 7 enters/leaves leveling
// - bit 12 set disables data outputs
// - termination pin switches only strobe termination
// - data pins undefined on leveling entry
// - exit write may update bits 12-8, 2-1
// - termination pin accepted after mode-update delay
// - strobe termination on after strobe-enable delay
// - strobe rise samples clock, drives after delay
// - feedback bits skew within skew window
// - no read strobe driven with feedback
// - x16 byte lanes report their own strobe
// - device terminates strobes, controller terminates data
// - data undefined until mode-update delay after exit
module wl_level (
  input wire logic clk,
  input wire logic rst_n,
  input wire wl_pkg::wl_cmd_t cmd,
  input wire wl_pkg::wl_strobe_t strobe,
  input wire logic ck_t,
  input wire logic odt,
  input wire wl_pkg::wl_avs_req_t avs_req,
  output wl_pkg::wl_avs_resp_t avs_resp,
  output wl_pkg::wl_pads_t pads
);
  localparam int MOD_DLY = `WL_MOD_CYC;
  localparam int DQSEN_DLY = `WL_DQSEN_CYC;
  localparam int FB_DLY = `WL_FB_CYC;

  wl_pkg::wl_state_t s_reg;
  wl_pkg::wl_state_t s_next;
  logic [5:0] synced;
  logic ck_lvl;
  logic u_diff;
  logic l_diff;
  logic odt_lvl;
  logic u_rise;
  logic l_rise;
  logic leveling;
  logic mr1_wr;
  logic illegal_evt;
  logic load_u;
  logic load_l;
  logic bus_take;

  wl_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pins({odt, strobe.lower_c, strobe.lower_t, strobe.upper_c, strobe.upper_t, ck_t}),
    .synced(synced)
  );

  // saturating count up, used by the mode counter
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == `WL_CNT_MAX) ? v : 8'(v + 8'h01);
  endfunction

  // true when the given byte lane is enabled; the caller checks that the write is taken
  function automatic logic lane_wr(input logic [3:0] be, input int lane);
    lane_wr = be[lane];
  endfunction

  function automatic logic [31:0] status_word(input wl_pkg::wl_state_t st);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`WL_ST_LEVEL_BIT] = (st.mode != wl_pkg::WL_IDLE);
    w[`WL_ST_QOFF_BIT] = st.mr1[`WL_MR1_QOFF_BIT];
    w[`WL_ST_ODT_OK_BIT] = (st.mode == wl_pkg::WL_ACTIVE);
    w[`WL_ST_STERM_BIT] = st.pads.strobe_term_on;
    w[`WL_ST_DEFINED_BIT] = st.pads.dq_defined;
    w[`WL_ST_UFB_BIT] = st.pads.dq[15];
    w[`WL_ST_LFB_BIT] = st.pads.dq[0];
    w[`WL_ST_ILLEGAL_BIT] = st.illegal;
    status_word = w;
  endfunction

  // differential strobe: true high, complement low counts as high
  assign ck_lvl = synced[0];
  assign u_diff = synced[1] & ~synced[2];
  assign l_diff = synced[3] & ~synced[4];
  assign odt_lvl = synced[5];
  assign u_rise = u_diff & ~s_reg.prev_u;
  assign l_rise = l_diff & ~s_reg.prev_l;
  assign leveling = (s_reg.mode != wl_pkg::WL_IDLE);
  assign mr1_wr = cmd.mrs && (cmd.mr_sel == `WL_MR_SEL_ONE);
  assign load_u = s_reg.pend[1] && (s_reg.cnt_u == 8'h00);
  assign load_l = s_reg.pend[0] && (s_reg.cnt_l == 8'h00);
  assign bus_take = (avs_req.read || avs_req.write) && !s_reg.avs.waitrequest;

  always_comb begin
    s_next = s_reg;
    illegal_evt = 1'b0;
    s_next.prev_u = u_diff;
    s_next.prev_l = l_diff;
    s_next.cnt = sat_inc(s_reg.cnt);

    unique case (s_reg.mode)
      wl_pkg::WL_IDLE: begin
        if (mr1_wr) begin
          s_next.mr1 = cmd.addr;
          if (cmd.addr[`WL_MR1_LEVEL_BIT]) begin
            s_next.mode = wl_pkg::WL_ENTRY;
            s_next.cnt = 8'h00;
          end
        end
      end
      wl_pkg::WL_ENTRY, wl_pkg::WL_ACTIVE: begin
        if (s_reg.mode == wl_pkg::WL_ENTRY && s_reg.cnt == 8'(MOD_DLY - 1)) begin
          s_next.mode = wl_pkg::WL_ACTIVE;
        end
        if (cmd.other || (cmd.mrs && !mr1_wr)) begin
          illegal_evt = 1'b1;
        end else if (mr1_wr && !cmd.addr[`WL_MR1_LEVEL_BIT]) begin
          // exit write may carry the listed fields, the rest stays
          s_next.mr1 = (s_reg.mr1 & ~`WL_MR1_EXIT_MASK) |
                       (cmd.addr & `WL_MR1_EXIT_MASK);
          s_next.mode = wl_pkg::WL_EXIT;
          s_next.cnt = 8'h00;
        end else if (mr1_wr) begin
          s_next.mr1[`WL_MR1_QOFF_BIT] = cmd.addr[`WL_MR1_QOFF_BIT];
          if ((cmd.addr & ~`WL_MR1_QOFF_MASK) != (s_reg.mr1 & ~`WL_MR1_QOFF_MASK)) begin
            illegal_evt = 1'b1;
          end
        end
      end
      wl_pkg::WL_EXIT: begin
        if (s_reg.cnt == 8'(MOD_DLY - 1)) begin
          s_next.mode = wl_pkg::WL_IDLE;
        end
        if (mr1_wr) begin
          s_next.mr1 = cmd.addr;
        end
      end
    endcase

    // strobe edges only count once the link is settled in leveling
    if (s_reg.mode == wl_pkg::WL_ACTIVE) begin
      if (u_rise) begin
        s_next.pend[1] = 1'b1;
        s_next.pend_lvl[1] = ck_lvl;
        s_next.cnt_u = 8'(FB_DLY - 1);
      end else if (load_u) begin
        s_next.pend[1] = 1'b0;
      end else if (s_reg.pend[1]) begin
        s_next.cnt_u = 8'(s_reg.cnt_u - 8'h01);
      end
      if (l_rise) begin
        s_next.pend[0] = 1'b1;
        s_next.pend_lvl[0] = ck_lvl;
        s_next.cnt_l = 8'(FB_DLY - 1);
      end else if (load_l) begin
        s_next.pend[0] = 1'b0;
      end else if (s_reg.pend[0]) begin
        s_next.cnt_l = 8'(s_reg.cnt_l - 8'h01);
      end
    end else begin
      s_next.pend = 2'h0;
    end

    // one register per lane, so all bits of a lane switch together
    if (s_reg.mode == wl_pkg::WL_ACTIVE) begin
      if (load_u && s_reg.x16) begin
        s_next.pads.dq[15:8] = {8{s_reg.pend_lvl[1]}};
        s_next.pads.dq_defined = 1'b1;
      end
      if (load_l) begin
        s_next.pads.dq[7:0] = {8{s_reg.pend_lvl[0]}};
        s_next.pads.dq_defined = 1'b1;
        if (!s_reg.x16) begin
          s_next.pads.dq[15:8] = {8{s_reg.pend_lvl[0]}};
        end
      end
    end
    // between edges the last level is simply held
    if (s_next.mode != s_reg.mode && s_next.mode != wl_pkg::WL_ACTIVE) begin
      s_next.pads.dq_defined = 1'b0;
    end

    s_next.pads.dq_oe_n = (s_next.mode == wl_pkg::WL_IDLE) ||
                          s_next.mr1[`WL_MR1_QOFF_BIT];
    s_next.pads.rdqs_oe_n = 1'b1;
    s_next.pads.strobe_term_on = (s_reg.mode == wl_pkg::WL_ACTIVE) &&
                                 (s_reg.cnt >= 8'(DQSEN_DLY));
    // before the update delay the pin is ignored and strobe termination stays off
    s_next.pads.strobe_term_nominal = (s_reg.mode == wl_pkg::WL_ACTIVE) && odt_lvl;
    s_next.pads.dq_term_on = !leveling && odt_lvl;

    // one wait state; the write lands on the edge that raises waitrequest again
    if ((avs_req.read || avs_req.write) && s_reg.avs.waitrequest) begin
      s_next.avs.waitrequest = 1'b0;
      unique case (avs_req.address)
        `WL_REG_CTRL: s_next.avs.readdata = {31'h0000_0000, s_reg.x16};
        `WL_REG_STATUS: s_next.avs.readdata = status_word(s_reg);
        `WL_REG_MR1: s_next.avs.readdata = {18'h0_0000, s_reg.mr1};
        default: s_next.avs.readdata = 32'h0000_0000;
      endcase
    end else begin
      s_next.avs.waitrequest = 1'b1;
    end
    if (bus_take && avs_req.write && avs_req.address == `WL_REG_CTRL &&
        lane_wr(avs_req.byteenable, 0)) begin
      s_next.x16 = avs_req.writedata[`WL_CTRL_X16_BIT];
    end
    // set wins: an event in the clearing cycle stays flagged
    if (bus_take && avs_req.write && avs_req.address == `WL_REG_STATUS &&
        lane_wr(avs_req.byteenable, 1) && avs_req.writedata[`WL_ST_ILLEGAL_BIT]) begin
      s_next.illegal = 1'b0;
    end
    if (illegal_evt) begin
      s_next.illegal = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
      s_reg.mode <= wl_pkg::WL_IDLE;
      s_reg.mr1 <= `WL_MR1_RST;
      s_reg.x16 <= `WL_CTRL_RST;
      s_reg.pads.dq_oe_n <= 1'b1;
      s_reg.pads.rdqs_oe_n <= 1'b1;
      s_reg.avs.waitrequest <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_resp = s_reg.avs;
  assign pads = s_reg.pads;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_entry_write;
    s_reg.mode == wl_pkg::WL_IDLE && mr1_wr && cmd.addr[`WL_MR1_LEVEL_BIT];
  endsequence

  sequence s_exit_write;
    s_reg.mode == wl_pkg::WL_ACTIVE && mr1_wr && !cmd.addr[`WL_MR1_LEVEL_BIT] && !cmd.other;
  endsequence

  sequence s_upper_high;
    s_reg.mode == wl_pkg::WL_ACTIVE && s_reg.x16 && u_rise && ck_lvl;
  endsequence

  a_entry_on_write: assert property (s_entry_write |=> s_reg.mode == wl_pkg::WL_ENTRY &&
    !pads.dq_defined)
    else $error("leveling entry not taken");

  a_exit_on_write: assert property (s_exit_write |=> s_reg.mode == wl_pkg::WL_EXIT
    ##1 (!pads.dq_defined)[*3])
    else $error("leveling exit not taken or data defined too early");

  a_exit_fields_kept: assert property (s_exit_write |=>
    (s_reg.mr1 & ~`WL_MR1_EXIT_MASK) == $past(s_reg.mr1 & ~`WL_MR1_EXIT_MASK))
    else $error("exit write changed a protected field");

  a_qoff_disables: assert property (s_reg.mr1[`WL_MR1_QOFF_BIT] |-> pads.dq_oe_n)
    else $error("data driven while outputs disabled");

  a_dq_term_off: assert property (leveling |=> !pads.dq_term_on)
    else $error("data termination on in leveling");

  a_odt_wait: assert property ($rose(s_reg.mode == wl_pkg::WL_ENTRY) |->
    (s_reg.mode == wl_pkg::WL_ENTRY)[*8] ##0 !pads.strobe_term_nominal)
    else $error("termination pin honoured before update delay");

  a_strobe_term: assert property ($rose(pads.strobe_term_on) |->
    $past(s_reg.cnt) >= 8'(DQSEN_DLY))
    else $error("strobe termination before enable delay");

  a_upper_feedback: assert property (s_upper_high ##1
    (s_reg.mode == wl_pkg::WL_ACTIVE && !u_rise)[*2] |=> pads.dq[15:8] == 8'hff)
    else $error("upper lane feedback wrong or late");

  a_no_read_strobe: assert property (leveling |-> pads.rdqs_oe_n)
    else $error("read strobe driven during leveling");

  a_hold_level: assert property (s_reg.mode == wl_pkg::WL_ACTIVE && !load_u && !load_l
    |=> $stable(pads.dq))
    else $error("feedback changed without a strobe sample");

  a_illegal_flag: assert property (s_reg.mode == wl_pkg::WL_ACTIVE && cmd.other
    |=> s_reg.illegal)
    else $error("disallowed command not flagged");
endmodule // wl_level

// ==== hdl/wl_pkg.sv ====
// types shared by the write-leveling block
package wl_pkg;

  typedef enum logic [1:0] {
    WL_IDLE = 2'h0,
    WL_ENTRY = 2'h1,
    WL_ACTIVE = 2'h3,
    WL_EXIT = 2'h2
  } wl_mode_t;

  typedef struct packed {
    logic mrs;
    logic other;
    logic [2:0] mr_sel;
    logic [13:0] addr;
  } wl_cmd_t;

  typedef struct packed {
    logic upper_t;
    logic upper_c;
    logic lower_t;
    logic lower_c;
  } wl_strobe_t;

  typedef struct packed {
    logic [15:0] dq;
    logic dq_oe_n;
    logic dq_defined;
    logic rdqs_oe_n;
    logic strobe_term_on;
    logic strobe_term_nominal;
    logic dq_term_on;
  } wl_pads_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } wl_avs_req_t;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } wl_avs_resp_t;

  typedef struct packed {
    logic [5:0] meta;
    logic [5:0] sync;
  } wl_sync_t;

  typedef struct packed {
    wl_mode_t mode;
    logic [7:0] cnt;
    logic [13:0] mr1;
    logic x16;
    logic illegal;
    logic prev_u;
    logic prev_l;
    logic [1:0] pend;
    logic [1:0] pend_lvl;
    logic [7:0] cnt_u;
    logic [7:0] cnt_l;
    wl_pads_t pads;
    wl_avs_resp_t avs;
  } wl_state_t;

endpackage

// ==== hdl/wl_regs.svh ====
// constants for the write-leveling block: timing, mode-register bits, register map
`ifndef WL_REGS_SVH
`define WL_REGS_SVH

`define WL_CLK_PERIOD_PS 4000
`define WL_MOD_DELAY_PS 60000
`define WL_DQSEN_DELAY_PS 100000
`define WL_FB_DELAY_PS 8000
// least times round up, the feedback delay is a longest time and rounds down
`define WL_MOD_CYC ((`WL_MOD_DELAY_PS + `WL_CLK_PERIOD_PS - 1) / `WL_CLK_PERIOD_PS)
`define WL_DQSEN_CYC ((`WL_DQSEN_DELAY_PS + `WL_CLK_PERIOD_PS - 1) / `WL_CLK_PERIOD_PS)
`define WL_FB_CYC (`WL_FB_DELAY_PS / `WL_CLK_PERIOD_PS)
`define WL_CNT_MAX 8'hff

`define WL_MR_SEL_ONE 3'h1
`define WL_MR1_LEVEL_BIT 7
`define WL_MR1_QOFF_BIT 12
`define WL_MR1_EXIT_MASK 14'h1f86
`define WL_MR1_QOFF_MASK 14'h1080
`define WL_MR1_RST 14'h0000

`define WL_REG_CTRL 4'h0
`define WL_REG_STATUS 4'h4
`define WL_REG_MR1 4'h8
`define WL_CTRL_X16_BIT 0
`define WL_CTRL_RST 1'h1
`define WL_ST_LEVEL_BIT 0
`define WL_ST_QOFF_BIT 1
`define WL_ST_ODT_OK_BIT 2
`define WL_ST_STERM_BIT 3
`define WL_ST_DEFINED_BIT 4
`define WL_ST_UFB_BIT 5
`define WL_ST_LFB_BIT 6
`define WL_ST_ILLEGAL_BIT 8

`endif

// ==== hdl/wl_sync.sv ====
// two-stage synchroniser for the pins sampled by the leveling logic
`timescale 1ns/100ps
module wl_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] pins,
  output logic [5:0] synced
);
  wl_pkg::wl_sync_t s_reg;
  wl_pkg::wl_sync_t s_next;

  always_comb begin
    s_next = s_reg;
    s_next.meta = pins;
    s_next.sync = s_reg.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign synced = s_reg.sync;
endmodule // wl_sync

// ==== verif/ddr4_write_leveling_tb.sv ====
// self-checking bench for the write-leveling block
`timescale 1ns/100ps
`include "wl_regs.svh"
module ddr4_write_leveling_tb;
  logic clk;
  logic rst_n;
  logic ck_t;
  wl_pkg::wl_cmd_t cmd;
  wl_pkg::wl_strobe_t strobe;
  logic odt;
  wl_pkg::wl_avs_req_t avs_req;
  wl_pkg::wl_avs_resp_t avs_resp;
  wl_pkg::wl_pads_t pads;
  int fail_count;
  int cmp_count;
  int seed;
  logic [31:0] rd;
  logic [13:0] ea;
  logic prev;
  logic fb;
  logic x16m;

  wl_level uut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .strobe(strobe), .ck_t(ck_t),
    .odt(odt), .avs_req(avs_req), .avs_resp(avs_resp), .pads(pads));
  wl_ctrl_model ctl (.clk(clk), .ck_t(ck_t), .cmd(cmd), .strobe(strobe), .odt(odt));

  always #2 clk = ~clk;
  // memory clock offset so its edges never line up with clk
  initial begin
    ck_t = 1'b0;
    #1.3;
    forever #62.5 ck_t = ~ck_t;
  end

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    avs_req <= '{read: !wr, write: wr, address: a, writedata: wd, byteenable: be};
    @(posedge clk);
    while (avs_resp.waitrequest !== 1'b0) begin
      n++;
      if (n > 50) begin
        fail_count++;
        wrap_up();
      end
      @(posedge clk);
    end
    rd = avs_resp.readdata;
    avs_req <= '0;
  endtask

  // 1 or 0 where ck is safely high or low at the strobe edge, 2 near a ck edge
  function automatic int exp_lvl(input realtime t);
    real p;
    p = t - 63.8;
    p = p - 125.0 * $floor(p / 125.0);
    if (p > 4.0 && p < 40.0) return 1;
    if (p > 67.0 && p < 103.0) return 0;
    return 2;
  endfunction

  task automatic shot(input logic up, input int dd, output logic f);
    logic [7:0] lane;
    logic [7:0] hold;
    int ex;
    hold = up ? pads.dq[7:0] : pads.dq[15:8];
    ctl.pulse(up, dd);
    repeat (12) @(posedge clk);
    ex = exp_lvl(ctl.t_rise);
    lane = up ? pads.dq[15:8] : pads.dq[7:0];
    f = lane[0];
    chk(32'(pads.rdqs_oe_n), 32'h1);
    if (!x16m && ex != 2) chk(32'(pads.dq), 32'({16{ex[0]}}));
    if (x16m) chk(32'(up ? pads.dq[7:0] : pads.dq[15:8]), 32'(hold));
    if (x16m && ex != 2) chk(32'(lane), 32'({8{ex[0]}}));
  endtask

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    avs_req = '0;
    seed = 32'he25d;
    fail_count = 0;
    cmp_count = 0;
    x16m = 1'b1;
    repeat (9) @(posedge clk);
    chk(32'(pads), 32'h28);
    chk(32'(avs_resp.waitrequest), 32'h1);
    @(posedge clk);
    rst_n <= 1'b1;
    av(1'b0, `WL_REG_CTRL, 32'h0, 4'hf);
    chk(rd, 32'h1);
    av(1'b1, `WL_REG_CTRL, 32'h0, 4'he);
    av(1'b1, 4'hc, 32'hffffffff, 4'hf);
    av(1'b0, 4'hc, 32'h0, 4'hf);
    chk(rd, 32'h0);
    av(1'b0, `WL_REG_CTRL, 32'h0, 4'hf);
    chk(rd, 32'h1);
    ctl.mrs(`WL_MR_SEL_ONE, 14'h0080, 1'b0);
    repeat (5) @(posedge clk);
    av(1'b0, `WL_REG_STATUS, 32'h0, 4'hf);
    chk(rd & 32'h1f, 32'h1);
    chk(32'(pads.dq_oe_n), 32'h0);
    repeat (10) @(posedge clk);
    av(1'b0, `WL_REG_STATUS, 32'h0, 4'hf);
    chk(rd & 32'h1f, 32'h5);
    ctl.set_odt(1'b1);
    repeat (6) @(posedge clk);
    chk(32'({pads.strobe_term_nominal, pads.dq_term_on}), 32'h2);
    ctl.drive_low();
    chk(32'(pads.strobe_term_on), 32'h1);
    prev = 1'b1;
    // sweep the upper strobe later until the feedback turns 0 to 1, then lock
    for (int d = 16; d < 44; d++) begin
      shot(1'b1, d, fb);
      if (prev === 1'b0 && fb === 1'b1) break;
      prev = fb;
    end
    chk(32'({prev, fb}), 32'h1);
    repeat (20) @(posedge clk);
    chk(32'({pads.dq_defined, pads.dq[15:8]}), 32'h1ff);
    av(1'b0, `WL_REG_STATUS, 32'h0, 4'hf);
    chk(rd & 32'h60, 32'h20);
    ctl.set_odt(1'b0);
    repeat (6) @(posedge clk);
    chk(32'({pads.strobe_term_nominal, pads.dq_term_on, pads.strobe_term_on}), 32'h1);
    for (int i = 0; i < 10; i++) shot(1'($random(seed)), $unsigned($random(seed)) % 32, fb);
    av(1'b1, `WL_REG_CTRL, 32'h0, 4'h1);
    x16m = 1'b0;
    for (int i = 0; i < 4; i++) shot(1'b0, $unsigned($random(seed)) % 32, fb);
    av(1'b1, `WL_REG_CTRL, 32'h1, 4'h1);
    x16m = 1'b1;
    ctl.mrs(`WL_MR_SEL_ONE, 14'h1080, 1'b0);
    repeat (4) @(posedge clk);
    chk(32'(pads.dq_oe_n), 32'h1);
    ctl.mrs(`WL_MR_SEL_ONE, 14'h0080, 1'b0);
    av(1'b0, `WL_REG_STATUS, 32'h0, 4'hf);
    chk(rd & 32'h103, 32'h1);
    // other command, write to another register, write touching a locked bit
    for (int k = 0; k < 3; k++) begin
      ctl.mrs(k == 1 ? 3'h2 : 3'h1, k == 2 ? 14'h0088 : 14'h0080, k == 0);
      av(1'b0, `WL_REG_STATUS, 32'h0, 4'hf);
      chk(rd & 32'h101, 32'h101);
      av(1'b1, `WL_REG_STATUS, 32'h100, 4'h2);
      av(1'b0, `WL_REG_STATUS, 32'h0, 4'hf);
      chk(rd & 32'h101, 32'h1);
    end
    av(1'b0, `WL_REG_MR1, 32'h0, 4'hf);
    chk(rd, 32'h80);
    ctl.release_strobes();
    repeat (8) @(posedge clk);
    ea = 14'($random(seed)) & 14'h3f7f;
    ctl.mrs(`WL_MR_SEL_ONE, ea, 1'b0);
    repeat (2) @(posedge clk);
    chk(32'(pads.dq_defined), 32'h0);
    repeat (20) @(posedge clk);
    av(1'b0, `WL_REG_MR1, 32'h0, 4'hf);
    chk(rd, 32'(ea & 14'h1f86));
    av(1'b0, `WL_REG_STATUS, 32'h0, 4'hf);
    chk(rd & 32'h1, 32'h0);
    wrap_up();
  end
endmodule // ddr4_write_leveling_tb

// ==== verif/wl_ctrl_model.sv ====
// controller-side model: commands, strobes and termination pin
`timescale 1ns/100ps
module wl_ctrl_model #(
  parameter int FIRST_CYC = 10
) (
  input wire logic clk,
  input wire logic ck_t,
  output wl_pkg::wl_cmd_t cmd,
  output wl_pkg::wl_strobe_t strobe,
  output logic odt
);
  realtime t_rise;
  // released strobes show t=c=1, never a clean high
  initial begin
    cmd = '0;
    strobe = 4'hf;
    odt = 1'b0;
    t_rise = 0;
  end
  // single-cycle command pulse, deselect otherwise
  task automatic mrs(input logic [2:0] sel, input logic [13:0] a, input logic oth);
    @(posedge clk);
    cmd <= '{mrs: !oth, other: oth, mr_sel: sel, addr: a};
    @(posedge clk);
    cmd <= '0;
  endtask
  task automatic set_odt(input logic v);
    @(posedge clk);
    odt <= v;
  endtask
  task automatic drive_low();
    @(posedge clk);
    strobe <= 4'h5;
  endtask
  task automatic release_strobes();
    @(posedge clk);
    strobe <= 4'hf;
  endtask
  // low width and first-strobe wait, then one rising edge at a phase of ck
  task automatic pulse(input logic up, input int d);
    repeat (FIRST_CYC) @(posedge clk);
    @(posedge ck_t);
    repeat (d + 1) @(posedge clk);
    strobe <= up ? 4'h9 : 4'h6;
    t_rise = $realtime;
    repeat (4) @(posedge clk);
    strobe <= 4'h5;
  endtask
endmodule // wl_ctrl_model
